/* File: rtl/flash_host_ctl.sv */
// Host controller sequencing program, pause, continue and abort
// What this block does
// - Program is two unlock writes, command byte, then address and data.
// - Pause is one write of its byte, any address, no unlock.
// - Host polls toggle bit at the address given with the command.
// - Continue is one write of its byte, any address, no unlock.
// - Host holds chip or write enable high during power-up.
`timescale 1ns/1ps
`default_nettype none

module flash_host_ctl #(
  parameter int PWRUP_CYC = flash_host_pkg::PWRUP_CYC
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // User command port
  input wire logic CMD_VALID_I,
  input wire logic [2:0] CMD_I,
  input wire logic [flash_host_pkg::AW-1:0] ADDR_I,
  input wire logic [flash_host_pkg::DW-1:0] DATA_I,
  input wire logic LOW_SUPPLY_I,
  // User status
  output logic BUSY_O,
  output logic DONE_O,
  output logic FAIL_O,
  output logic SUSPENDED_O,
  output logic [flash_host_pkg::DW-1:0] RDATA_O,
  // Flash pins
  input wire logic [flash_host_pkg::DW-1:0] FL_DQ_I,
  output logic [flash_host_pkg::DW-1:0] FL_DQ_O,
  output logic FL_DQ_OE_O,
  output logic [flash_host_pkg::AW-1:0] FL_ADDR_O,
  output logic FL_CE_N_O,
  output logic FL_OE_N_O,
  output logic FL_WE_N_O
);

  // ----------------------------------------------------------------
  // Write word of each step of a sequence
  // ----------------------------------------------------------------
  function automatic logic [flash_host_pkg::AW+flash_host_pkg::DW-1:0]
      seq_word(input flash_host_pkg::op_t op, input logic [1:0] step,
               input logic [flash_host_pkg::AW-1:0] addr,
               input logic [flash_host_pkg::DW-1:0] data);
    logic [flash_host_pkg::AW+flash_host_pkg::DW-1:0] w;
    w = {addr, flash_host_pkg::CMD_ABORT};
    unique case (op)
      flash_host_pkg::OP_PROGRAM: begin
        unique case (step)
          2'h0: w = {flash_host_pkg::UNLOCK1_ADDR,
                     flash_host_pkg::UNLOCK1_DATA};
          2'h1: w = {flash_host_pkg::UNLOCK2_ADDR,
                     flash_host_pkg::UNLOCK2_DATA};
          2'h2: w = {flash_host_pkg::UNLOCK1_ADDR,
                     flash_host_pkg::CMD_PROGRAM};
          2'h3: w = {addr, data};
        endcase
      end
      flash_host_pkg::OP_PAUSE: w = {addr, flash_host_pkg::CMD_PAUSE};
      flash_host_pkg::OP_CONTINUE: w = {addr,
                                        flash_host_pkg::CMD_CONTINUE};
      default: w = {addr, flash_host_pkg::CMD_ABORT};
    endcase
    return w;
  endfunction : seq_word

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  flash_bus_if bus ();
  flash_host_pkg::ctl_state_t state, next_state;
  flash_host_pkg::op_t op, next_op, cmd_op;
  logic [1:0] step, next_step;
  logic [flash_host_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [flash_host_pkg::AW-1:0] addr_l, next_addr_l;
  logic [flash_host_pkg::DW-1:0] data_l, next_data_l, next_rdata;
  logic first, next_first, prev_tog, next_prev_tog;
  logic fail_seen, next_fail_seen, low_meta, low_sync;
  logic next_busy, next_done, next_fail, next_susp;
  logic next_req, next_wr, tog;
  logic [flash_host_pkg::AW+flash_host_pkg::DW-1:0] next_word;

  // Suspend wait bounds at counter width
  localparam logic [flash_host_pkg::CNT_W-1:0] CNT_W_SUSP_MIN =
      flash_host_pkg::CNT_W'(flash_host_pkg::SUSP_MIN_CYC);
  localparam logic [flash_host_pkg::CNT_W-1:0] CNT_W_SUSP_MAX =
      flash_host_pkg::CNT_W'(flash_host_pkg::SUSP_MAX_CYC);

  assign cmd_op = flash_host_pkg::op_t'(CMD_I);
  assign tog = bus.rdata[flash_host_pkg::TOGGLE_BIT];

  // Sequencer next values
  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_cnt = cnt;
    next_addr_l = addr_l;
    next_data_l = data_l;
    next_first = first;
    next_prev_tog = prev_tog;
    next_fail_seen = fail_seen;
    next_busy = BUSY_O;
    next_done = 1'b0;
    next_fail = FAIL_O;
    next_susp = SUSPENDED_O;
    next_rdata = RDATA_O;
    next_req = 1'b0;
    next_wr = bus.wr;
    next_word = {bus.addr, bus.wdata};
    unique case (state)
      flash_host_pkg::S_PWRUP: begin
        next_cnt = cnt - 1'b1;
        if (cnt == '0) begin
          next_busy = 1'b0;
          next_state = flash_host_pkg::S_IDLE;
        end
      end
      flash_host_pkg::S_IDLE: begin
        if (CMD_VALID_I) begin
          next_op = cmd_op;
          next_addr_l = ADDR_I;
          next_data_l = DATA_I;
          next_step = 2'h0;
          next_fail = 1'b0;
          if (cmd_op != flash_host_pkg::OP_READ && low_sync) begin
            next_done = 1'b1;
            next_fail = 1'b1;
          end else if ((cmd_op == flash_host_pkg::OP_PROGRAM
                        && SUSPENDED_O)
                       || (cmd_op == flash_host_pkg::OP_CONTINUE
                           && !SUSPENDED_O)) begin
            next_done = 1'b1;
            next_fail = 1'b1;
          end else begin
            next_busy = 1'b1;
            next_req = 1'b1;
            next_wr = (cmd_op != flash_host_pkg::OP_READ);
            next_word = seq_word(cmd_op, 2'h0, ADDR_I, DATA_I);
            next_state = flash_host_pkg::S_ACCESS;
          end
        end
      end
      flash_host_pkg::S_ACCESS: begin
        if (bus.ack) begin
          next_cnt = '0;
          next_first = 1'b1;
          next_fail_seen = 1'b0;
          if (op == flash_host_pkg::OP_READ) begin
            next_rdata = bus.rdata;
            next_done = 1'b1;
            next_busy = 1'b0;
            next_state = flash_host_pkg::S_IDLE;
          end else if (op == flash_host_pkg::OP_PROGRAM
                       && step != flash_host_pkg::LAST_PROG_STEP) begin
            next_step = step + 2'h1;
            next_req = 1'b1;
            next_word = seq_word(op, step + 2'h1, addr_l, data_l);
          end else if (op == flash_host_pkg::OP_PROGRAM) begin
            // Poll the target byte for status
            next_req = 1'b1;
            next_wr = 1'b0;
            next_word = {addr_l, data_l};
            next_state = flash_host_pkg::S_POLL;
          end else if (op == flash_host_pkg::OP_PAUSE) begin
            next_state = flash_host_pkg::S_SETTLE;
          end else begin
            next_susp = 1'b0;
            next_done = 1'b1;
            next_busy = 1'b0;
            next_state = flash_host_pkg::S_IDLE;
          end
        end
      end
      flash_host_pkg::S_SETTLE: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= CNT_W_SUSP_MIN) begin
          next_req = 1'b1;
          next_wr = 1'b0;
          next_word = {addr_l, data_l};
          next_state = flash_host_pkg::S_POLL;
        end
      end
      flash_host_pkg::S_POLL: begin
        next_cnt = cnt + 1'b1;
        if (bus.ack) begin
          next_first = 1'b0;
          next_prev_tog = tog;
          next_fail_seen = bus.rdata[flash_host_pkg::FAIL_BIT];
          next_rdata = bus.rdata;
          if (!first && tog == prev_tog) begin
            // Toggle stopped: operation over or erase held
            next_done = 1'b1;
            next_busy = 1'b0;
            next_susp = (op == flash_host_pkg::OP_PAUSE);
            next_state = flash_host_pkg::S_IDLE;
          end else if (!first && (fail_seen || (op
                       == flash_host_pkg::OP_PAUSE
                       && cnt >= CNT_W_SUSP_MAX))) begin
            next_done = 1'b1;
            next_fail = 1'b1;
            next_busy = 1'b0;
            next_state = flash_host_pkg::S_IDLE;
          end else begin
            next_req = 1'b1;
            next_word = {addr_l, data_l};
          end
        end
      end
      default: next_state = flash_host_pkg::S_IDLE;
    endcase
  end

  // Sequencer registers; power-up wait keeps strobes high
  always_ff @(posedge CLK_I) begin
    low_meta <= LOW_SUPPLY_I;
    low_sync <= low_meta;
    if (RST_I) begin
      state <= flash_host_pkg::S_PWRUP;
      op <= flash_host_pkg::OP_READ;
      step <= 2'h0;
      cnt <= flash_host_pkg::CNT_W'(PWRUP_CYC - 1);
      addr_l <= '0;
      data_l <= '0;
      first <= 1'b1;
      prev_tog <= 1'b0;
      fail_seen <= 1'b0;
      BUSY_O <= 1'b1;
      DONE_O <= 1'b0;
      FAIL_O <= 1'b0;
      SUSPENDED_O <= 1'b0;
      RDATA_O <= '0;
      bus.req <= 1'b0;
      bus.wr <= 1'b0;
      bus.addr <= '0;
      bus.wdata <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      cnt <= next_cnt;
      addr_l <= next_addr_l;
      data_l <= next_data_l;
      first <= next_first;
      prev_tog <= next_prev_tog;
      fail_seen <= next_fail_seen;
      BUSY_O <= next_busy;
      DONE_O <= next_done;
      FAIL_O <= next_fail;
      SUSPENDED_O <= next_susp;
      RDATA_O <= next_rdata;
      bus.req <= next_req;
      bus.wr <= next_wr;
      {bus.addr, bus.wdata} <= next_word;
    end
  end

  // Pin engine
  flash_strobe_engine engine (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .bus(bus.eng),
    .dq_i(FL_DQ_I),
    .addr_o(FL_ADDR_O),
    .dq_o(FL_DQ_O),
    .dq_oe_o(FL_DQ_OE_O),
    .ce_n_o(FL_CE_N_O),
    .oe_n_o(FL_OE_N_O),
    .we_n_o(FL_WE_N_O)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  property p_pwrup_quiet;
    state == flash_host_pkg::S_PWRUP |-> BUSY_O && FL_WE_N_O && FL_CE_N_O;
  endproperty
  a_pwrup_quiet: assert property (p_pwrup_quiet)
    else $error("strobe active during power-up");

  property p_lockout;
    state == flash_host_pkg::S_IDLE && CMD_VALID_I && low_sync
      && cmd_op != flash_host_pkg::OP_READ
      |=> DONE_O && FAIL_O && !bus.req ##1 FL_WE_N_O [*3];
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("write started under low supply");

  property p_cont_refused;
    state == flash_host_pkg::S_IDLE && CMD_VALID_I && !low_sync
      && !SUSPENDED_O && cmd_op == flash_host_pkg::OP_CONTINUE
      |=> DONE_O && FAIL_O && state == flash_host_pkg::S_IDLE;
  endproperty
  a_cont_refused: assert property (p_cont_refused)
    else $error("continue accepted with nothing suspended");

  property p_prog_refused;
    state == flash_host_pkg::S_IDLE && CMD_VALID_I && !low_sync
      && SUSPENDED_O && cmd_op == flash_host_pkg::OP_PROGRAM
      |=> DONE_O && FAIL_O && SUSPENDED_O;
  endproperty
  a_prog_refused: assert property (p_prog_refused)
    else $error("program issued while suspended");

  property p_prog_words;
    bus.req && bus.wr && op == flash_host_pkg::OP_PROGRAM
      |-> (step == 2'h2 && bus.wdata == flash_host_pkg::CMD_PROGRAM)
       || (step == 2'h3 && bus.addr == addr_l && bus.wdata == data_l)
       || step < 2'h2;
  endproperty
  a_prog_words: assert property (p_prog_words)
    else $error("program sequence word wrong");

  property p_pause_wait;
    $rose(state == flash_host_pkg::S_POLL) && op == flash_host_pkg::OP_PAUSE
      |-> cnt > CNT_W_SUSP_MIN;
  endproperty
  a_pause_wait: assert property (p_pause_wait)
    else $error("pause polled too early");

  property p_pause_single;
    bus.req && bus.wr && (op == flash_host_pkg::OP_PAUSE
      || op == flash_host_pkg::OP_CONTINUE) |-> step == 2'h0;
  endproperty
  a_pause_single: assert property (p_pause_single)
    else $error("unlock cycles before pause or continue");

  c_prog_done: cover property (op == flash_host_pkg::OP_PROGRAM
                               && DONE_O && !FAIL_O);
  c_suspended: cover property ($rose(SUSPENDED_O));
  c_resumed: cover property ($fell(SUSPENDED_O) && DONE_O);
  c_read_done: cover property (op == flash_host_pkg::OP_READ && DONE_O);

endmodule : flash_host_ctl

`default_nettype wire

/* File: rtl/flash_host_pkg.sv */
// Shared constants and types for the parallel flash host controller
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Rounding helpers
  // ----------------------------------------------------------------
  function automatic int ceil_div(input int num, input int den);
    return (num + den - 1) / den;
  endfunction : ceil_div

  function automatic int floor_div(input int num, input int den);
    return num / den;
  endfunction : floor_div

  // ----------------------------------------------------------------
  // Timing, in printed units, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 45;         // Write strobe low
  localparam int T_WPH_NS = 20;        // Strobe high recovery
  localparam int T_ACC_NS = 150;       // Read access
  localparam int T_SUSP_MIN_NS = 100;  // Pause takes effect, least
  localparam int T_SUSP_MAX_NS = 15000;  // Pause takes effect, most
  localparam int T_VCS_US = 50;        // Supply up to first strobe
  localparam int SYNC_STAGES = 2;
  localparam int WP_CYC = ceil_div(T_WP_NS, CLK_NS);
  localparam int WPH_CYC = ceil_div(T_WPH_NS, CLK_NS);
  localparam int ACC_CYC = ceil_div(T_ACC_NS, CLK_NS);
  localparam int SUSP_MIN_CYC = ceil_div(T_SUSP_MIN_NS, CLK_NS);
  localparam int SUSP_MAX_CYC = floor_div(T_SUSP_MAX_NS, CLK_NS);
  localparam int PWRUP_CYC = ceil_div(T_VCS_US * 1000, CLK_NS);
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Bus widths, command bytes and status bit positions
  // ----------------------------------------------------------------
  localparam int AW = 19;
  localparam int DW = 8;
  localparam logic [AW-1:0] UNLOCK1_ADDR = 19'h05555;
  localparam logic [AW-1:0] UNLOCK2_ADDR = 19'h02AAA;
  localparam logic [DW-1:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [DW-1:0] UNLOCK2_DATA = 8'h55;
  localparam logic [DW-1:0] CMD_PROGRAM = 8'hA0;
  localparam logic [DW-1:0] CMD_PAUSE = 8'hB0;
  localparam logic [DW-1:0] CMD_CONTINUE = 8'h30;
  localparam logic [DW-1:0] CMD_ABORT = 8'hF0;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int TIMER_BIT = 3;
  localparam logic [1:0] LAST_PROG_STEP = 2'h3;

  // ----------------------------------------------------------------
  // User operations and state machines
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_PAUSE = 3'h2,
    OP_CONTINUE = 3'h3,
    OP_ABORT = 3'h4
  } op_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'h0,
    E_WLOW = 2'h1,
    E_RWAIT = 2'h2,
    E_REC = 2'h3
  } eng_state_t;

  typedef enum logic [2:0] {
    S_PWRUP = 3'h0,
    S_IDLE = 3'h1,
    S_ACCESS = 3'h2,
    S_SETTLE = 3'h3,
    S_POLL = 3'h4
  } ctl_state_t;

endpackage : flash_host_pkg

/* File: rtl/flash_bus_if.sv */
// Single-access request channel between sequencer and strobe engine
`timescale 1ns/1ps
`default_nettype none

interface flash_bus_if;
  logic req;
  logic wr;
  logic [flash_host_pkg::AW-1:0] addr;
  logic [flash_host_pkg::DW-1:0] wdata;
  logic [flash_host_pkg::DW-1:0] rdata;
  logic ack;

  modport seq (output req, wr, addr, wdata, input rdata, ack);
  modport eng (input req, wr, addr, wdata, output rdata, ack);
endinterface : flash_bus_if

`default_nettype wire

/* File: rtl/flash_strobe_engine.sv */
// Pin-level strobe engine: one write or read cycle per request
`timescale 1ns/1ps
`default_nettype none

module flash_strobe_engine (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request channel
  flash_bus_if.eng bus,
  // Flash pins
  input wire logic [flash_host_pkg::DW-1:0] dq_i,
  output logic [flash_host_pkg::AW-1:0] addr_o,
  output logic [flash_host_pkg::DW-1:0] dq_o,
  output logic dq_oe_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  flash_host_pkg::eng_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic [flash_host_pkg::DW-1:0] dq_meta, dq_sync;
  logic [flash_host_pkg::AW-1:0] next_addr;
  logic [flash_host_pkg::DW-1:0] next_dq, next_rdata;
  logic next_dq_oe, next_ce_n, next_oe_n, next_we_n, next_ack;

  // Next-value logic for the strobe sequence
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr = addr_o;
    next_dq = dq_o;
    next_dq_oe = dq_oe_o;
    next_ce_n = ce_n_o;
    next_oe_n = oe_n_o;
    next_we_n = we_n_o;
    next_rdata = bus.rdata;
    next_ack = 1'b0;
    unique case (state)
      flash_host_pkg::E_IDLE: begin
        if (bus.req) begin
          next_addr = bus.addr;
          next_ce_n = 1'b0;
          if (bus.wr) begin
            // Address taken by the device on the falling strobe
            next_dq = bus.wdata;
            next_dq_oe = 1'b1;
            next_we_n = 1'b0;
            next_cnt = 8'(flash_host_pkg::WP_CYC - 1);
            next_state = flash_host_pkg::E_WLOW;
          end else begin
            next_oe_n = 1'b0;
            next_cnt = 8'(flash_host_pkg::ACC_CYC
                          + flash_host_pkg::SYNC_STAGES - 1);
            next_state = flash_host_pkg::E_RWAIT;
          end
        end
      end
      flash_host_pkg::E_WLOW: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          // Rising strobe latches the data byte
          next_we_n = 1'b1;
          next_ce_n = 1'b1;
          next_cnt = 8'(flash_host_pkg::WPH_CYC - 1);
          next_state = flash_host_pkg::E_REC;
        end
      end
      flash_host_pkg::E_RWAIT: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_rdata = dq_sync;
          next_oe_n = 1'b1;
          next_ce_n = 1'b1;
          next_cnt = 8'(flash_host_pkg::WPH_CYC - 1);
          next_state = flash_host_pkg::E_REC;
        end
      end
      flash_host_pkg::E_REC: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_dq_oe = 1'b0;
          next_ack = 1'b1;
          next_state = flash_host_pkg::E_IDLE;
        end
      end
    endcase
  end

  // Registers; strobes idle high from reset onward
  always_ff @(posedge clk_i) begin
    dq_meta <= dq_i;
    dq_sync <= dq_meta;
    if (rst_i) begin
      state <= flash_host_pkg::E_IDLE;
      cnt <= 8'h00;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      bus.rdata <= '0;
      bus.ack <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      addr_o <= next_addr;
      dq_o <= next_dq;
      dq_oe_o <= next_dq_oe;
      ce_n_o <= next_ce_n;
      oe_n_o <= next_oe_n;
      we_n_o <= next_we_n;
      bus.rdata <= next_rdata;
      bus.ack <= next_ack;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_we_width;
    $fell(we_n_o) |-> (!we_n_o && dq_oe_o && !ce_n_o) [*5] ##1 we_n_o;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width wrong");

  property p_no_clash;
    !(!oe_n_o && !we_n_o) && !(dq_oe_o && !oe_n_o);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("read and write strobes overlap");

  property p_ack_bound;
    (state == flash_host_pkg::E_IDLE && bus.req) |-> ##[8:20] bus.ack;
  endproperty
  a_ack_bound: assert property (p_ack_bound)
    else $error("access not acknowledged in time");

endmodule : flash_strobe_engine

`default_nettype wire

/* File: testbench/flash_dev_model.sv */
// Behavioural parallel flash device driven by the host controller
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  // Strobes, supply and erase trigger
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic low_i,
  input wire logic erase_i,
  // Address and data
  input wire logic [18:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o
);
  logic [7:0] mem [0:255];
  logic [18:0] la;
  logic [7:0] pd, last = 8'h00;
  logic [1:0] step = 2'h0;
  logic busy = 1'b0, ers = 1'b0, susp = 1'b0, pz = 1'b0, tog = 1'b0;
  int wcnt = 0;
  wire wr_n = we_n_i | ce_n_i;
  wire rd_n = oe_n_i | ce_n_i;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  // Address on falling strobe, command or data on rising
  always @(negedge wr_n) la = addr_i;
  always @(posedge wr_n) wcnt++;
  always @(posedge wr_n) if (!low_i && !busy) begin
    if (step == 2'h3) begin
      pd = dq_i;
      step = 2'h0;
      busy = 1'b1;
      mem[la[7:0]] = mem[la[7:0]] & dq_i;
    end else if (ers && !susp) begin
      if (dq_i == 8'hB0) pz = 1'b1;
      if (dq_i == 8'hF0) ers = 1'b0;
    end else if (susp) begin
      if (dq_i == 8'h30 || dq_i == 8'hF0) susp = 1'b0;
      if (dq_i == 8'hF0) ers = 1'b0;
    end else if (step == 2'h0 && la == 19'h05555 && dq_i == 8'hAA) begin
      step = 2'h1;
    end else if (step == 2'h1 && la == 19'h02AAA && dq_i == 8'h55) begin
      step = 2'h2;
    end else begin
      step = (step == 2'h2 && dq_i == 8'hA0) ? 2'h3 : 2'h0;
    end
  end
  // Program and suspend latencies
  always @(posedge busy) #10000 busy = 1'b0;
  always @(posedge pz) #2000 begin
    susp = 1'b1;
    pz = 1'b0;
  end
  // Erase never ends on its own; only an abort byte written to the device ends it
  always @(posedge erase_i) ers = 1'b1;
  // Toggle advances on each status read
  always @(negedge rd_n) if (busy || (ers && !susp)) tog = ~tog;
  always @(dq_o) if (!rd_n) last = dq_o;
  // Read path; a released bus shows the inverse of the last value
  always_comb begin
    if (rd_n) dq_o = ~last;
    else if (busy) dq_o = {~pd[7], tog, 6'h00};
    else if (ers && !susp) dq_o = {1'b0, tog, 2'h0, 1'b1, 3'h0};
    else if (ers && addr_i[18:16] == 3'h7) dq_o = ~mem[addr_i[7:0]];
    else dq_o = mem[addr_i[7:0]];
  end
endmodule : flash_dev_model
`default_nettype wire

/* File: testbench/flash_program_suspend_resume_ctl_test.sv */
// Self-checking bench for the flash program and suspend controller
`timescale 1ns/1ps
`default_nettype none
module flash_program_suspend_resume_ctl_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic vld = 1'b0, low = 1'b0, ers = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic [18:0] adr = 19'h00000, fa;
  logic [7:0] dat = 8'h00, rdata, dq_h, dq_f, w;
  logic busy, done, fail, susp, dq_oe, ce_n, oe_n, we_n;
  int mismatches = 0, samples_checked = 0;
  wire logic [7:0] dq = dq_oe ? dq_h : dq_f;
  wire logic [7:0] st = {5'h00, busy, fail, susp};
  // Clock
  initial forever #5 clk_i = ~clk_i;
  flash_host_ctl #(.PWRUP_CYC(20)) uut (
    .CLK_I(clk_i), .RST_I(rst_i), .CMD_VALID_I(vld), .CMD_I(cmd),
    .ADDR_I(adr), .DATA_I(dat), .LOW_SUPPLY_I(low), .BUSY_O(busy),
    .DONE_O(done), .FAIL_O(fail), .SUSPENDED_O(susp), .RDATA_O(rdata),
    .FL_DQ_I(dq), .FL_DQ_O(dq_h), .FL_DQ_OE_O(dq_oe), .FL_ADDR_O(fa),
    .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n), .FL_WE_N_O(we_n));
  flash_dev_model fd (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .low_i(low), .erase_i(ers), .addr_i(fa), .dq_i(dq), .dq_o(dq_f));
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One command; reads check data, others check the status flags
  task automatic run(input logic [2:0] c, input logic [7:0] d,
                     input logic [7:0] e);
    int n;
    n = 0;
    @(posedge clk_i);
    #1 vld = 1'b1;
    cmd = c;
    dat = d;
    adr = 19'h00005;
    @(posedge clk_i);
    #1 vld = 1'b0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge clk_i);
      #1 n++;
    end
    // No completion within the limit counts as a mismatch
    if (n >= 5000) mismatches++;
    chk(c == 3'h0 ? rdata : st, e);
  endtask : run
  // Verdict
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk(st, 8'h04);
    repeat (22) @(posedge clk_i);
    #1 chk(st, 8'h00);
    run(3'h0, 8'h00, 8'hFF);
    run(3'h1, 8'h3C, 8'h00);
    run(3'h0, 8'h00, 8'h3C);
    run(3'h1, 8'hF0, 8'h00);
    run(3'h0, 8'h00, 8'h30);
    run(3'h3, 8'h00, 8'h02);
    ers = 1'b1;
    run(3'h2, 8'h00, 8'h01);
    run(3'h0, 8'h00, 8'h30);
    run(3'h1, 8'h00, 8'h03);
    run(3'h3, 8'h00, 8'h00);
    run(3'h2, 8'h00, 8'h01);
    run(3'h4, 8'h00, 8'h00);
    chk({7'h00, fd.ers}, 8'h00);
    run(3'h2, 8'h00, 8'h01);
    chk({7'h00, fd.susp}, 8'h00);
    run(3'h4, 8'h00, 8'h00);
    low = 1'b1;
    w = fd.wcnt[7:0];
    repeat (3) @(posedge clk_i);
    run(3'h1, 8'h00, 8'h02);
    chk(fd.wcnt[7:0], w);
    finish_test();
  end
  // Watchdog
  initial begin
    #300000;
    mismatches++;
    finish_test();
  end
endmodule : flash_program_suspend_resume_ctl_test
`default_nettype wire
